//--- include/dpcr_pkg.sv
package dpcr_pkg;
    // Register offsets
    localparam logic [7:0] OFS_FORMAT = 8'h14;
    localparam logic [7:0] OFS_CHIP = 8'h16;
    localparam logic [7:0] OFS_PERIOD = 8'h17;
    localparam logic [7:0] OFS_RSVD = 8'h18;
    localparam logic [7:0] OFS_RSP_L = 8'h19;
    localparam logic [7:0] OFS_RSP_H = 8'h1A;
    localparam logic [7:0] OFS_BLK_L = 8'h1B;
    localparam logic [7:0] OFS_BLK_H = 8'h1C;
    localparam logic [7:0] OFS_TAG = 8'h1D;
    localparam int NUM_REGS = 9;
    localparam int FIRST_OFS = 8'h14;
    // Field positions and reset values
    localparam int POS_DATA_WIDTH = 1;
    localparam int POS_STAT_WIDTH = 0;
    localparam logic [7:0] RST_VAL = 8'h00;
    // Field masks of writable bits
    localparam logic [7:0] MSK_FORMAT = 8'h03;
    localparam logic [7:0] MSK_SEL3 = 8'h07;
    localparam logic [7:0] MSK_HIGH = 8'h0F;
    localparam logic [7:0] MSK_FULL = 8'hFF;
    // Field lengths
    localparam logic [4:0] DATA_LEN_SHORT = 5'h0A;
    localparam logic [4:0] DATA_LEN_LONG = 5'h0E;
    localparam logic [2:0] STAT_LEN_ON = 3'h4;
    localparam logic [2:0] STAT_LEN_OFF = 3'h0;
    // Times, in half microseconds for chip time, microseconds otherwise
    localparam int CLK_MHZ = 25;
    localparam logic [3:0] CHIP_BASE_HALF_US = 4'h6;
    localparam logic [11:0] RSP_MIN_US = 12'h014;
    localparam logic [11:0] BLK_DEFAULT_US = 12'h1C2;
    localparam logic [11:0] PER_0_US = 12'h1F4;
    localparam logic [11:0] PER_1_US = 12'h07D;
    localparam logic [11:0] PER_2_US = 12'h0FA;
    localparam logic [11:0] PER_3_US = 12'h14D;
    localparam logic [11:0] PER_5_US = 12'h3E8;
    localparam logic [11:0] PER_6_US = 12'h7D0;
    localparam logic [11:0] PER_7_US = 12'hFA0;
    // Cycles per microsecond at the 25 MHz clock
    localparam logic [4:0] CYC_PER_US = 5'(CLK_MHZ);
    // Access result codes
    typedef enum logic [1:0] {ACC_OK, ACC_UNMAPPED, ACC_LOCKED} dpcr_acc_e;
endpackage

//--- include/dpcr_store_if.sv
interface dpcr_store_if;
    import dpcr_pkg::*;
    logic we;
    logic [3:0] waddr;
    logic [7:0] wdata;
    logic [3:0] raddr;
    logic [7:0] rdata;
    logic [8*NUM_REGS-1:0] image;
    modport owner (output we, output waddr, output wdata, output raddr,
        input rdata, input image);
    modport store (input we, input waddr, input wdata, input raddr,
        output rdata, output image);
endinterface

//--- src/dpcr_store.sv
module dpcr_store
    import dpcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Access port
    dpcr_store_if.store sp
);
    logic [7:0] mem_r [NUM_REGS];
    logic [7:0] mem_nxt [NUM_REGS];
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (sp.we && (int'(sp.waddr) < NUM_REGS)) begin
            mem_nxt[sp.waddr] = sp.wdata;
        end
        rdata_nxt = (int'(sp.raddr) < NUM_REGS) ? mem_r[sp.raddr] : RST_VAL;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                mem_r[i] <= RST_VAL;
            end
            rdata_r <= RST_VAL;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                mem_r[i] <= mem_nxt[i];
            end
            rdata_r <= rdata_nxt;
        end
    end

    assign sp.rdata = rdata_r;

    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : g_img
            assign sp.image[8*g +: 8] = mem_r[g];
        end
    endgenerate
endmodule

//--- src/dpcr_regs.sv
// Contract
// R1: A data-width select of 0 gives a 10-bit data field, 1 gives a 14-bit field.
// R2: The 14-bit field keeps the short sensitivity and adds four test-only upper range bits.
// R3: A status-width select of 0 gives a 4-bit status field, 1 drops the status field.
// R4: Chip duration is 3.0 us plus 0.5 us per step of the 3-bit select.
// R5: The period select maps 000..111 to 500,125,250,333,500,1000,2000,4000 us.
// R6: The period drives oscillator training only while clock calibration is enabled.
// R7: Periodic and diagnostic commands are answered whatever the period field holds.
// R8: Response start time is the 12-bit value in us, with 0 to 20 giving 20 us.
// R9: The master avoids start times that make sensors collide on the bus.
// R10: Command blocking time is the 12-bit value in us, with 0 giving 450 us.
// R11: The bus high level is captured when blocking ends and then filtered.
// R12: The master ends blocking when the bus is quiet so the sample is stable.
// R13: After reset the sender tag is loaded from the stored physical address.
// R14: All these registers are user read/write and take part in integrity checking; OFS_RSVD has a zero write mask, so it keeps no written bits.
// R15: Oscillator training over the bus runs only while clock calibration is set.
// R16: Unused upper bits read as zero and ignore writes.
module dpcr_regs
    import dpcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register access from command and response decoding
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_unmapped,
    // Device state
    input wire logic [3:0] phys_addr,
    input wire logic clock_calibration_enable,
    input wire logic periodic_enabled,
    input wire logic blocking_end,
    input wire logic [7:0] bus_high_level,
    // Decoded settings
    output logic [4:0] data_len,
    output logic upper_range_en,
    output logic [2:0] stat_len,
    output logic [3:0] chip_half_us,
    output logic [11:0] train_period_us,
    output logic train_active,
    output logic [11:0] rsp_start_us,
    output logic [11:0] blk_time_us,
    output logic [4:0] us_cycles,
    output logic [7:0] bus_high_filt,
    output logic [3:0] sender_tag,
    output logic rw_array_error
);
    ////////////////////////////////////////////////////////////////////////
    dpcr_store_if sif ();

    dpcr_store u_store (
        .clk(clk),
        .rst(rst),
        .sp(sif.store)
    );

    function automatic logic [7:0] wmask(input logic [3:0] idx);
        unique case (idx)
            4'h0: wmask = MSK_FORMAT;
            4'h1, 4'h2: wmask = MSK_SEL3;
            4'h5, 4'h7, 4'h8: wmask = MSK_HIGH;
            4'h3: wmask = 8'h00;
            4'h4, 4'h6: wmask = MSK_FULL;
            default: wmask = 8'h00;
        endcase
    endfunction

    // Storage slots skip the unmapped hole just above the format register
    function automatic logic [3:0] slot(input logic [7:0] a);
        slot = (a > OFS_FORMAT) ? 4'(a - OFS_CHIP) + 4'h1 : 4'(a - OFS_FORMAT);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a >= OFS_FORMAT) && (a <= OFS_TAG) && (a != 8'h15);
    endfunction

    function automatic logic [7:0] regv(input logic [8*NUM_REGS-1:0] img,
            input logic [3:0] idx);
        regv = img[8*idx +: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    typedef enum {ST_FILL_A, ST_FILL_B, ST_LOAD_TAG, ST_RUN} dpcr_state_e;
    dpcr_state_e state_r, state_nxt;
    logic [3:0] idx;
    logic rd_pend_r, rd_pend_nxt;
    logic unm_r, unm_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] shadow_r [NUM_REGS];
    logic [7:0] shadow_nxt [NUM_REGS];
    logic err_r, err_nxt;
    logic [3:0] addr_s1_r, addr_s2_r, addr_s3_r;

    assign idx = slot(reg_addr);

    // Physical address arrives from the storage array domain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_s1_r <= 4'h0;
            addr_s2_r <= 4'h0;
            addr_s3_r <= 4'h0;
        end else begin
            addr_s1_r <= phys_addr;
            addr_s2_r <= addr_s1_r;
            addr_s3_r <= addr_s2_r;
        end
    end

    always_comb begin
        state_nxt = state_r;
        sif.we = 1'b0;
        sif.waddr = idx;
        sif.wdata = reg_wdata & wmask(idx); // R16
        sif.raddr = idx;
        rd_pend_nxt = 1'b0;
        unm_nxt = 1'b0;
        rdata_nxt = rdata_r;
        err_nxt = err_r;
        for (int i = 0; i < NUM_REGS; i++) begin
            shadow_nxt[i] = shadow_r[i];
        end
        unique case (state_r)
            // Let the address synchroniser fill before its stages are compared
            ST_FILL_A: begin
                state_nxt = ST_FILL_B;
            end
            ST_FILL_B: begin
                state_nxt = ST_LOAD_TAG;
            end
            ST_LOAD_TAG: begin
                if (addr_s2_r == addr_s3_r) begin
                    sif.we = 1'b1; // R13
                    sif.waddr = slot(OFS_TAG);
                    sif.wdata = {4'h0, addr_s3_r};
                    shadow_nxt[slot(OFS_TAG)] = {4'h0, addr_s3_r};
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (reg_wr && mapped(reg_addr)) begin
                    sif.we = 1'b1; // R14
                    shadow_nxt[idx] = reg_wdata & wmask(idx);
                end
                if ((reg_wr || reg_rd) && !mapped(reg_addr)) begin
                    unm_nxt = 1'b1;
                end
                rd_pend_nxt = reg_rd && mapped(reg_addr);
            end
        endcase
        if (rd_pend_r) begin
            rdata_nxt = sif.rdata;
        end
        // Integrity check of the storage against its shadow copy
        if (periodic_enabled && state_r == ST_RUN) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                if (regv(sif.image, 4'(i)) != shadow_r[i]) begin
                    err_nxt = 1'b1; // R14
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_FILL_A;
            rd_pend_r <= 1'b0;
            unm_r <= 1'b0;
            rdata_r <= RST_VAL;
            err_r <= 1'b0;
            for (int i = 0; i < NUM_REGS; i++) begin
                shadow_r[i] <= RST_VAL;
            end
        end else begin
            state_r <= state_nxt;
            rd_pend_r <= rd_pend_nxt;
            unm_r <= unm_nxt;
            rdata_r <= rdata_nxt;
            err_r <= err_nxt;
            for (int i = 0; i < NUM_REGS; i++) begin
                shadow_r[i] <= shadow_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded settings, registered
    logic [7:0] fmt, chp, per, rsl, rsh, bkl, bkh, tag;
    logic [11:0] rsp_raw, blk_raw;
    logic [4:0] dlen_nxt;
    logic uprng_nxt;
    logic [2:0] slen_nxt;
    logic [3:0] chip_nxt;
    logic [11:0] per_nxt, rsp_nxt, blk_nxt;
    logic train_nxt;
    logic [7:0] filt_r, filt_nxt, cap_r, cap_nxt;
    logic cap_v_r, cap_v_nxt;
    logic [4:0] dlen_r, uscyc_r;
    logic uprng_r, train_r;
    logic [2:0] slen_r;
    logic [3:0] chip_r, tag_r;
    logic [11:0] per_r, rsp_r, blk_r;
    logic rv_r;

    assign fmt = regv(sif.image, slot(OFS_FORMAT));
    assign chp = regv(sif.image, slot(OFS_CHIP));
    assign per = regv(sif.image, slot(OFS_PERIOD));
    assign rsl = regv(sif.image, slot(OFS_RSP_L));
    assign rsh = regv(sif.image, slot(OFS_RSP_H));
    assign bkl = regv(sif.image, slot(OFS_BLK_L));
    assign bkh = regv(sif.image, slot(OFS_BLK_H));
    assign tag = regv(sif.image, slot(OFS_TAG));
    assign rsp_raw = {rsh[3:0], rsl};
    assign blk_raw = {bkh[3:0], bkl};

    always_comb begin
        dlen_nxt = fmt[POS_DATA_WIDTH] ? DATA_LEN_LONG : DATA_LEN_SHORT; // R1
        uprng_nxt = fmt[POS_DATA_WIDTH]; // R2
        slen_nxt = fmt[POS_STAT_WIDTH] ? STAT_LEN_OFF : STAT_LEN_ON; // R3
        chip_nxt = CHIP_BASE_HALF_US + {1'b0, chp[2:0]}; // R4
        unique case (per[2:0]) // R5
            3'h0: per_nxt = PER_0_US;
            3'h1: per_nxt = PER_1_US;
            3'h2: per_nxt = PER_2_US;
            3'h3: per_nxt = PER_3_US;
            3'h4: per_nxt = PER_0_US;
            3'h5: per_nxt = PER_5_US;
            3'h6: per_nxt = PER_6_US;
            3'h7: per_nxt = PER_7_US;
        endcase
        // Period only steers training; command decoding never looks at it
        train_nxt = clock_calibration_enable; // R6 R7 R15
        if (!clock_calibration_enable) begin
            per_nxt = 12'h000; // R6
        end
        rsp_nxt = (rsp_raw <= RSP_MIN_US) ? RSP_MIN_US : rsp_raw; // R8
        blk_nxt = (blk_raw == 12'h000) ? BLK_DEFAULT_US : blk_raw; // R10
        cap_nxt = cap_r;
        cap_v_nxt = cap_v_r;
        filt_nxt = filt_r;
        if (blocking_end) begin
            cap_nxt = bus_high_level; // R11
            cap_v_nxt = 1'b1;
        end else if (cap_v_r) begin
            // First-order filter: move half way toward the captured sample
            filt_nxt = 8'((9'(filt_r) + 9'(cap_r)) >> 1); // R11
            if (filt_r == cap_r) begin
                cap_v_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dlen_r <= DATA_LEN_SHORT;
            uprng_r <= 1'b0;
            slen_r <= STAT_LEN_ON;
            chip_r <= CHIP_BASE_HALF_US;
            per_r <= 12'h000;
            train_r <= 1'b0;
            rsp_r <= RSP_MIN_US;
            blk_r <= BLK_DEFAULT_US;
            uscyc_r <= CYC_PER_US;
            cap_r <= RST_VAL;
            cap_v_r <= 1'b0;
            filt_r <= RST_VAL;
            tag_r <= 4'h0;
            rv_r <= 1'b0;
        end else begin
            dlen_r <= dlen_nxt;
            uprng_r <= uprng_nxt;
            slen_r <= slen_nxt;
            chip_r <= chip_nxt;
            per_r <= per_nxt;
            train_r <= train_nxt;
            rsp_r <= rsp_nxt;
            blk_r <= blk_nxt;
            uscyc_r <= CYC_PER_US;
            cap_r <= cap_nxt;
            cap_v_r <= cap_v_nxt;
            filt_r <= filt_nxt;
            tag_r <= tag[3:0]; // R13
            rv_r <= rd_pend_r;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rv_r;
    assign reg_unmapped = unm_r;
    assign data_len = dlen_r;
    assign upper_range_en = uprng_r;
    assign stat_len = slen_r;
    assign chip_half_us = chip_r;
    assign train_period_us = per_r;
    assign train_active = train_r;
    assign rsp_start_us = rsp_r;
    assign blk_time_us = blk_r;
    assign us_cycles = uscyc_r;
    assign bus_high_filt = filt_r;
    assign sender_tag = tag_r;
    assign rw_array_error = err_r;
endmodule

//--- verif/dpcr_regs_monitor.sv
module dpcr_regs_monitor
    import dpcr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic reg_unmapped,
    // Settings
    input wire logic clock_calibration_enable,
    input wire logic upper_range_en,
    input wire logic [2:0] stat_len,
    input wire logic [3:0] chip_half_us,
    input wire logic [11:0] train_period_us,
    input wire logic [11:0] rsp_start_us,
    input wire logic [11:0] blk_time_us,
    input wire logic rw_array_error
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_fmt;
        reg_wr && reg_addr == OFS_FORMAT |-> ##2 upper_range_en == $past(reg_wdata[1], 2)
            && stat_len == ($past(reg_wdata[0], 2) ? 3'h0 : 3'h4);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format fields wrong");
    property p_chip;
        reg_wr && reg_addr == OFS_CHIP |-> ##2 chip_half_us == 4'h6 + $past(reg_wdata[2:0], 2);
    endproperty
    a_chip: assert property (p_chip) else $error("chip time wrong");
    property p_per_off;
        !clock_calibration_enable [*3] |-> train_period_us == 12'h000;
    endproperty
    a_per_off: assert property (p_per_off) else $error("period used while off");
    property p_rsp_min;
        rsp_start_us >= 12'h014;
    endproperty
    a_rsp_min: assert property (p_rsp_min) else $error("start time below floor");
    property p_blk;
        blk_time_us != 12'h000;
    endproperty
    a_blk: assert property (p_blk) else $error("blocking time zero");
    property p_rd;
        reg_rd && (reg_addr == OFS_FORMAT || (reg_addr >= OFS_CHIP && reg_addr <= OFS_TAG))
            |-> ##2 reg_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_rv_cause;
        reg_rvalid |-> $past(reg_rd, 2);
    endproperty
    a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
    property p_zero;
        reg_rd && reg_addr == OFS_FORMAT |-> ##2 reg_rdata[7:2] == 6'h00;
    endproperty
    a_zero: assert property (p_zero) else $error("unused bits read set");
    property p_unm;
        (reg_wr || reg_rd) && reg_addr == 8'h15 |=> reg_unmapped;
    endproperty
    a_unm: assert property (p_unm) else $error("hole not flagged");
    property p_sticky;
        rw_array_error |=> rw_array_error;
    endproperty
    a_sticky: assert property (p_sticky) else $error("error flag dropped");
    c_fmt: cover property (reg_wr && reg_addr == OFS_FORMAT);
    c_rd: cover property (reg_rvalid);
    c_unm: cover property (reg_unmapped);
endmodule
bind dpcr_regs dpcr_regs_monitor dpcr_regs_monitor_inst (.clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .reg_unmapped, .clock_calibration_enable,
    .upper_range_en, .stat_len, .chip_half_us, .train_period_us, .rsp_start_us,
    .blk_time_us, .rw_array_error);

//--- verif/dpcr_master.sv
module dpcr_master
    import dpcr_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register access
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    // Bus sampling
    output logic blocking_end,
    output logic [7:0] bus_high_level
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {reg_wr, reg_rd, blocking_end} = 3'h0;
        {reg_addr, reg_wdata, bus_high_level} = 24'h000000;
    end
    // One strobe per access; released lines are scrambled
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = wr ? d : ~reg_wdata;
        @(negedge clk);
        {reg_wr, reg_rd} = 2'h0;
        reg_addr = ~a;
        reg_wdata = ~reg_wdata;
    endtask
    // Blocking ends only while no access is in flight; level moves away afterwards
    task automatic end_block(input logic [7:0] lvl);
        @(negedge clk);
        bus_high_level = lvl;
        blocking_end = 1'h1;
        @(negedge clk);
        blocking_end = 1'h0;
        bus_high_level = ~lvl;
    endtask
endmodule

//--- verif/dpcr_regs_tb.sv
module dpcr_regs_tb
    import dpcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst = 1'h1, cal = 1'h0, pen = 1'h0;
    logic [3:0] phys_addr = 4'hA;
    logic reg_wr, reg_rd, reg_rvalid, reg_unmapped, blocking_end, upper_range_en;
    logic train_active, rw_array_error;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, bus_high_level, bus_high_filt;
    logic [4:0] data_len, us_cycles;
    logic [2:0] stat_len;
    logic [3:0] chip_half_us, sender_tag;
    logic [11:0] train_period_us, rsp_start_us, blk_time_us;
    logic [7:0] exp_q[$];
    logic [7:0] v;
    int n_mismatch = 0, comparisons = 0, n_unm = 0;
    logic [7:0] ofs[9] = '{8'h14, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D};
    logic [7:0] msk[9] = '{8'h03, 8'h07, 8'h07, 8'h00, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h0F};
    logic [11:0] per[8] = '{12'h1F4, 12'h07D, 12'h0FA, 12'h14D, 12'h1F4, 12'h3E8, 12'h7D0,
        12'hFA0};
    logic [11:0] tv[4] = '{12'h000, 12'h014, 12'h015, 12'hFFF};
    always #20 clk = ~clk;
    dpcr_master dpcr_master_inst (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .blocking_end, .bus_high_level);
    dpcr_regs dpcr_regs_inst (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .reg_unmapped, .phys_addr, .clock_calibration_enable(cal),
        .periodic_enabled(pen), .blocking_end, .bus_high_level, .data_len, .upper_range_en,
        .stat_len, .chip_half_us, .train_period_us, .train_active, .rsp_start_us,
        .blk_time_us, .us_cycles, .bus_high_filt, .sender_tag, .rw_array_error);
    task automatic check(string nm, logic [11:0] seen, logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        dpcr_master_inst.acc(1'h1, a, d);
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        exp_q.push_back(e);
        dpcr_master_inst.acc(1'h0, a, 8'h00);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Read answers are matched in order against the noted values
    always @(negedge clk) begin
        if (reg_unmapped === 1'h1) n_unm++;
        if (reg_rvalid === 1'h1) begin
            if (exp_q.size() == 0) check("extra read", 12'h001, 12'h000);
            else check("read data", 12'(reg_rdata), 12'(exp_q.pop_front()));
        end
    end
    initial begin
        #(4000 * 40);
        n_mismatch++;
        summarize();
    end
    initial begin
        void'($urandom(69276));
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 1'h0;
        repeat (6) @(negedge clk);
        foreach (ofs[i]) rd(ofs[i], (ofs[i] == OFS_TAG) ? 8'h0A : 8'h00);
        check("tag", 12'(sender_tag), 12'h00A);
        check("us", 12'(us_cycles), 12'h019);
        $display("test reset done");
        pen = 1'h1;
        foreach (ofs[i]) begin
            v = 8'($urandom);
            wr(ofs[i], v);
            rd(ofs[i], v & msk[i]);
        end
        $display("test storage done");
        for (int i = 0; i < 4; i++) begin
            wr(OFS_FORMAT, 8'hFC | 8'(i));
            check("data_len", 12'(data_len), i[1] ? 12'h00E : 12'h00A);
            check("upper", 12'(upper_range_en), 12'(i[1]));
            check("stat_len", 12'(stat_len), i[0] ? 12'h000 : 12'h004);
        end
        cal = 1'h1;
        for (int i = 0; i < 8; i++) begin
            wr(OFS_CHIP, 8'(i));
            check("chip", 12'(chip_half_us), 12'(6 + i));
            wr(OFS_PERIOD, 8'(i));
            check("period", train_period_us, per[i]);
        end
        check("train", 12'(train_active), 12'h001);
        cal = 1'h0;
        wr(OFS_PERIOD, 8'h05);
        check("period off", train_period_us, 12'h000);
        check("train off", 12'(train_active), 12'h000);
        $display("test decode done");
        foreach (tv[i]) begin
            wr(OFS_RSP_L, tv[i][7:0]);
            wr(OFS_RSP_H, 8'hF0 | 8'(tv[i][11:8]));
            check("rsp", rsp_start_us, (tv[i] <= 12'h014) ? 12'h014 : tv[i]);
            wr(OFS_BLK_L, tv[i][7:0]);
            wr(OFS_BLK_H, 8'hF0 | 8'(tv[i][11:8]));
            check("blk", blk_time_us, (tv[i] == 12'h000) ? 12'h1C2 : tv[i]);
        end
        $display("test times done");
        wr(OFS_FORMAT, 8'h02);
        wr(8'h15, 8'h01);
        dpcr_master_inst.acc(1'h0, 8'h30, 8'h00);
        rd(OFS_FORMAT, 8'h02);
        repeat (4) @(negedge clk);
        check("unmapped", 12'(n_unm), 12'h002);
        $display("test unmapped done");
        repeat (12) dpcr_master_inst.end_block(8'hC8);
        repeat (3) @(negedge clk);
        check("filter", 12'(bus_high_filt >= 8'hC6 && bus_high_filt <= 8'hC8), 12'h001);
        check("integrity", 12'(rw_array_error), 12'h000);
        check("queue", 12'(exp_q.size()), 12'h000);
        $display("test sampling done");
        phys_addr = 4'h5;
        rst = 1'h1;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        repeat (6) @(negedge clk);
        check("tag again", 12'(sender_tag), 12'h005);
        check("len again", 12'(data_len), 12'h00A);
        rd(OFS_TAG, 8'h05);
        repeat (4) @(negedge clk);
        check("queue again", 12'(exp_q.size()), 12'h000);
        $display("test reset again done");
        summarize();
    end
endmodule
